// file: gxt_pkg.sv
// Purpose: Shared constants for the chain extender link control block.
// Assumes: A 125 MHz system clock and an AXI4-Lite register port.
// Notes: Times are in nanoseconds; cycle counts are derived from them.
package gxt_pkg;
   // ==========================================================
   // Clock and timing.
   localparam int CLK_NS = 8;
   localparam int T_PPOLL_NORM_NS = 22000;
   localparam int T_PPOLL_SLOW_NS = 220000;
   localparam int T_ECHO_NORM_NS = 1000000;
   localparam int T_ECHO_SLOW_NS = 10000000;
   localparam int PPOLL_NORM_CYC = T_PPOLL_NORM_NS / CLK_NS;
   localparam int PPOLL_SLOW_CYC = T_PPOLL_SLOW_NS / CLK_NS;
   localparam int ECHO_NORM_CYC = T_ECHO_NORM_NS / CLK_NS;
   localparam int ECHO_SLOW_CYC = T_ECHO_SLOW_NS / CLK_NS;
   localparam int TMR_W = 24;
   // ==========================================================
   // Register map.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   // CTRL fields.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SLOW_BIT = 1;
   localparam int CTRL_POS_LSB = 2;
   localparam int CTRL_FIBA_BIT = 4;
   localparam int CTRL_FIBB_BIT = 5;
   localparam int CTRL_UPB_BIT = 6;
   localparam int CTRL_W = 7;
   // ==========================================================
   // Node positions and port masks.
   localparam logic [1:0] POS_MASTER = 2'h0;
   localparam logic [1:0] POS_MIDDLE = 2'h1;
   localparam logic [1:0] POS_END = 2'h2;
   localparam logic [1:0] PORT_A = 2'h1;
   localparam logic [1:0] PORT_B = 2'h2;
   localparam logic [1:0] PORT_NONE = 2'h0;
   localparam logic [1:0] PORT_BOTH = 2'h3;
   // ==========================================================
   // State machines.
   typedef enum logic [2:0] {HS_IDLE, HS_WAIT_ACK, HS_WAIT_DAV_HI, HS_WAIT_DROP} gxt_hs_e;
   typedef enum logic [1:0] {TR_IDLE, TR_WAIT} gxt_tr_e;
endpackage

// file: gxt_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to aclk.
// Notes: The output follows only when stages two and three agree.
`timescale 1ns/10ps
module gxt_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q <= INIT;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   end
endmodule

// file: gxt_link_ctrl.sv
// Purpose: Link control for one node of a chained instrument bus extender.
// Assumes: Link serialiser is same-clock logic; bus pins are asynchronous.
// Notes: Registers are reached over AXI4-Lite.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module gxt_link_ctrl #(
   parameter int ECHO_NORM = gxt_pkg::ECHO_NORM_CYC,
   parameter int ECHO_SLOW = gxt_pkg::ECHO_SLOW_CYC,
   parameter int PPOLL_SLOW = gxt_pkg::PPOLL_SLOW_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ifc_n,
   input wire logic atn_n,
   input wire logic eoi_n,
   input wire logic dav_n,
   input wire logic [7:0] dio_n,
   output logic nrfd_o,
   output logic nrfd_oe_n,
   output logic ndac_o,
   output logic ndac_oe_n,
   output logic [7:0] dio_o,
   output logic [7:0] dio_oe_n,
   output logic [7:0] link_data,
   output logic link_req,
   input wire logic [1:0] link_ack,
   output logic [1:0] link_probe,
   input wire logic [1:0] link_echo,
   output logic link_ppoll,
   input wire logic [7:0] link_ppr,
   output logic link_slow,
   output logic [1:0] fault_led
);
   import gxt_pkg::*;

   localparam logic [TMR_W-1:0] ECHO_N = TMR_W'(ECHO_NORM);
   localparam logic [TMR_W-1:0] ECHO_S = TMR_W'(ECHO_SLOW);
   localparam logic [TMR_W-1:0] PP_N = TMR_W'(PPOLL_NORM_CYC);
   localparam logic [TMR_W-1:0] PP_S = TMR_W'(PPOLL_SLOW);
   localparam logic [TMR_W-1:0] TMR_ZERO = '0;
   localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

   // ==========================================================
   // Pin synchronisers.
   logic [11:0] pins_s;
   logic ifc_s;
   logic atn_s;
   logic eoi_s;
   logic dav_s;
   logic [7:0] dio_s;
   logic ifc_q;

   gxt_pin_sync #(.W(12), .INIT(12'hfff)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({ifc_n, atn_n, eoi_n, dav_n, dio_n}),
      .q(pins_s)
   );
   assign {ifc_s, atn_s, eoi_s, dav_s, dio_s} = pins_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ifc_q <= 1'b1;
      end else begin
         ifc_q <= ifc_s;
      end
   end

   // ==========================================================
   // Register state and configuration decode.
   logic [CTRL_W-1:0] ctrl;
   logic [1:0] cut;
   logic [15:0] attempts;
   logic cfg_en;
   logic [1:0] cfg_pos;
   logic cfg_block;
   logic [1:0] used;
   logic [1:0] down;
   logic [1:0] act;
   logic ack_all;
   logic drop_all;
   gxt_hs_e hs_state;
   gxt_tr_e tr_state;

   assign cfg_en = ctrl[CTRL_EN_BIT];
   assign cfg_pos = ctrl[CTRL_POS_LSB +: 2];
   // A cut below the master needs coax: fibre on a non-master node blocks it.
   assign cfg_block = (cfg_pos != POS_MASTER) &&
                      (ctrl[CTRL_FIBA_BIT] || ctrl[CTRL_FIBB_BIT]);
   assign used = (cfg_pos == POS_MIDDLE) ? PORT_BOTH : PORT_A;
   always_comb begin
      if (cfg_pos == POS_MASTER) begin
         down = PORT_A;
      end else if (cfg_pos == POS_MIDDLE) begin
         down = ctrl[CTRL_UPB_BIT] ? PORT_A : PORT_B;
      end else begin
         down = PORT_NONE;
      end
   end
   assign act = used & ~cut;
   assign ack_all = &(link_ack | ~act);
   assign drop_all = ~|(link_ack & act);
   assign link_slow = ctrl[CTRL_SLOW_BIT];

   // ==========================================================
   // AXI4-Lite slave.
   logic aw_have;
   logic w_have;
   logic [3:0] aw_addr;
   logic [31:0] wdata_q;
   logic wstrb_q;

   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready = !w_have && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrl <= CTRL_RESET[CTRL_W-1:0];
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr[3:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            if (aw_have || s_axi_awvalid) begin
               // Write data is held here until the address is known.
            end
         end
         if (aw_have && w_have) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == ADDR_CTRL) begin
               s_axi_bresp <= RESP_OKAY;
               if (wstrb_q) begin
                  ctrl <= wdata_q[CTRL_W-1:0];
               end
            end else if (aw_addr == ADDR_STATUS || aw_addr == ADDR_COUNT) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_q <= 32'h0;
         wstrb_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb[0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr[3:0] == ADDR_CTRL) begin
            s_axi_rdata <= {25'h0, ctrl};
         end else if (s_axi_araddr[3:0] == ADDR_STATUS) begin
            s_axi_rdata <= {26'h0, cfg_block, tr_state == TR_WAIT, fault_led, cut};
         end else if (s_axi_araddr[3:0] == ADDR_COUNT) begin
            s_axi_rdata <= {16'h0, attempts};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Three-wire handshake relay. The node is a listener that always
   // accepts, and holds NDAC until every live port has taken the byte.
   // Each link's round trip is what adds the per-hop handshake time.
   assign nrfd_o = 1'b0;
   assign ndac_o = 1'b0;
   assign dio_o = 8'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_state <= HS_IDLE;
         nrfd_oe_n <= 1'b1;
         ndac_oe_n <= 1'b0;
         link_req <= 1'b0;
         link_data <= 8'h0;
      end else begin
         case (hs_state)
            HS_IDLE: begin
               if (!dav_s) begin
                  link_data <= ~dio_s;
                  nrfd_oe_n <= 1'b0;
                  link_req <= 1'b1;
                  hs_state <= HS_WAIT_ACK;
               end
            end
            HS_WAIT_ACK: begin
               if (ack_all) begin
                  ndac_oe_n <= 1'b1;
                  hs_state <= HS_WAIT_DAV_HI;
               end
            end
            HS_WAIT_DAV_HI: begin
               if (dav_s) begin
                  ndac_oe_n <= 1'b0;
                  link_req <= 1'b0;
                  hs_state <= HS_WAIT_DROP;
               end
            end
            HS_WAIT_DROP: begin
               if (drop_all) begin
                  nrfd_oe_n <= 1'b1;
                  hs_state <= HS_IDLE;
               end
            end
            default: hs_state <= HS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Truncation: each IFC with truncation enabled, no fibre block and no probe pending probes the downstream
   // port and waits a bounded time for the echo. Only the echo decides,
   // so hung or unpowered local devices can never trigger a cut.
   logic [TMR_W-1:0] echo_tmr;
   logic [1:0] seen;
   logic ifc_fall;
   assign ifc_fall = ifc_q && !ifc_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tr_state <= TR_IDLE;
         echo_tmr <= TMR_ZERO;
         seen <= PORT_NONE;
         cut <= PORT_NONE;
         fault_led <= PORT_NONE;
         link_probe <= PORT_NONE;
         attempts <= 16'h0;
      end else begin
         link_probe <= PORT_NONE;
         if (!cfg_en || cfg_block) begin
            tr_state <= TR_IDLE;
            cut <= PORT_NONE;
            fault_led <= PORT_NONE;
         end else begin
            case (tr_state)
               TR_IDLE: begin
                  // IFC during an ongoing probe is absorbed; spacing is the controller's.
                  if (ifc_fall) begin
                     link_probe <= down;
                     seen <= PORT_NONE;
                     echo_tmr <= link_slow ? ECHO_S : ECHO_N;
                     attempts <= attempts + 16'h1;
                     tr_state <= TR_WAIT;
                  end
               end
               TR_WAIT: begin
                  seen <= seen | (link_echo & down);
                  echo_tmr <= echo_tmr - TMR_ONE;
                  if (echo_tmr == TMR_ZERO) begin
                     cut <= down & ~(seen | link_echo);
                     fault_led <= down & ~(seen | link_echo);
                     tr_state <= TR_IDLE;
                  end
               end
               default: tr_state <= TR_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // Parallel poll relay. Remote answers are OR-ed onto the local lines
   // for a bounded window; local devices answer directly and unhindered.
   logic [TMR_W-1:0] pp_tmr;
   logic ident;
   logic pp_active;
   assign ident = !atn_s && !eoi_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pp_tmr <= TMR_ZERO;
         pp_active <= 1'b0;
         link_ppoll <= 1'b0;
         dio_oe_n <= 8'hff;
      end else if (!ident) begin
         pp_active <= 1'b0;
         link_ppoll <= 1'b0;
         dio_oe_n <= 8'hff;
      end else if (!link_ppoll && !pp_active) begin
         if (act != PORT_NONE) begin
            link_ppoll <= 1'b1;
            pp_active <= 1'b1;
            pp_tmr <= link_slow ? PP_S : PP_N;
         end
      end else if (pp_active) begin
         pp_tmr <= pp_tmr - TMR_ONE;
         dio_oe_n <= ~link_ppr;
         if (pp_tmr == TMR_ZERO) begin
            pp_active <= 1'b0;
            dio_oe_n <= 8'hff;
         end
      end
   end

   // ==========================================================
   // Assertions.
   sequence ifc_probe_s;
      ifc_fall && cfg_en && !cfg_block && tr_state == TR_IDLE;
   endsequence
   sequence idle_byte_s;
      hs_state == HS_IDLE && !dav_s && act == PORT_NONE ##1 act == PORT_NONE;
   endsequence

   ack_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ndac_oe_n) |-> $past(ack_all) && $past(hs_state) == HS_WAIT_ACK)
      else $error("NDAC released before all ports acknowledged.");
   ifc_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ifc_probe_s |=> tr_state == TR_WAIT && link_probe == down)
      else $error("IFC did not start a truncation attempt.");
   probe_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      link_probe != PORT_NONE |=> link_probe == PORT_NONE)
      else $error("Probe pulse longer than one cycle.");
   cut_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cut & ~$past(cut)) != PORT_NONE |-> $past(tr_state) == TR_WAIT &&
      $past(echo_tmr) == TMR_ZERO)
      else $error("Port cut without an echo timeout.");
   cut_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tr_state != TR_WAIT && cfg_en && !cfg_block) ##1 (cfg_en && !cfg_block)
      |-> $stable(cut))
      else $error("Cut changed outside an echo check.");
   listen_always_a: assert property (@(posedge aclk) disable iff (!aresetn)
      idle_byte_s |=> ndac_oe_n)
      else $error("Byte not accepted with no live ports.");
   ppoll_window_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dio_oe_n != 8'hff |-> $past(ident) && $past(pp_active))
      else $error("Poll lines driven outside the answer window.");
   fiber_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_block |=> cut == PORT_NONE && tr_state == TR_IDLE)
      else $error("Truncation active on a blocked fibre configuration.");
endmodule

// file: gxt_far_node.sv
// Purpose: Behavioural model of the neighbouring nodes seen through the link ports.
// Assumes: Same clock as the link control block; ports A and B answer together.
// Notes: Ack and echo delays are set by the bench to play a fast or slow neighbour.
`timescale 1ns/10ps
module gxt_far_node (
   input wire logic aclk,
   input wire logic link_req,
   input wire logic [1:0] link_probe,
   input wire logic link_ppoll,
   input wire logic [7:0] ack_dly,
   input wire logic [7:0] echo_dly,
   input wire logic [1:0] echo_on,
   input wire logic [7:0] ppr_val,
   output logic [1:0] link_ack,
   output logic [1:0] link_echo,
   output logic [7:0] link_ppr
);
   logic [7:0] req_cnt = 8'h0;
   logic [7:0] echo_cnt = 8'h0;
   logic [1:0] echo_port = 2'h0;
   logic [7:0] idle_pat = 8'h5a;
   // ==========================================================
   // Byte relay: the far node takes the byte after a set delay.
   always_ff @(posedge aclk) begin
      if (!link_req) begin
         req_cnt <= 8'h0;
      end else if (req_cnt != 8'hff) begin
         req_cnt <= req_cnt + 8'h1;
      end
   end
   assign link_ack = (link_req && req_cnt >= ack_dly) ? 2'h3 : 2'h0;
   // ==========================================================
   // Echo: a probe comes back late, or never on a broken port.
   always_ff @(posedge aclk) begin
      if (link_probe != 2'h0) begin
         echo_port <= link_probe & echo_on;
         echo_cnt <= 8'h1;
      end else if (echo_cnt != 8'h0) begin
         echo_cnt <= (echo_cnt == echo_dly) ? 8'h0 : echo_cnt + 8'h1;
      end
      idle_pat <= ~idle_pat;
   end
   assign link_echo = (echo_cnt == echo_dly) ? echo_port : 2'h0;
   // Outside a poll the answer lines carry a changing pattern, never stale data.
   assign link_ppr = link_ppoll ? ppr_val : idle_pat;
endmodule

// file: gxt_link_ctrl_tb.sv
// Purpose: Self-checking bench for the chain extender link control block.
// Assumes: Shortened echo counts and slow poll count; the far side is the behavioural node model.
// Notes: Outputs are sampled at the rising edge, before that edge's updates land.
`timescale 1ns/10ps
module gxt_link_ctrl_tb;
   import gxt_pkg::*;
   localparam int ES = 40;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, lq = 32'h8ac9;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp, ack, probe, echo, fault_led, echo_on = 2'h0;
   logic ifc_n = 1'b1, atn_n = 1'b1, eoi_n = 1'b1, dav_n = 1'b1;
   logic [7:0] dio_n = 8'hff, dio_oe_n, link_data, ppr, ppr_val = 8'h0;
   logic [7:0] ack_dly = 8'h4, echo_dly = 8'h4;
   logic nrfd_oe_n, ndac_oe_n, link_req, link_ppoll, link_slow;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   gxt_link_ctrl #(.ECHO_NORM(20), .ECHO_SLOW(ES), .PPOLL_SLOW(30)) dut (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ifc_n(ifc_n),
      .atn_n(atn_n), .eoi_n(eoi_n), .dav_n(dav_n), .dio_n(dio_n), .nrfd_o(),
      .nrfd_oe_n(nrfd_oe_n), .ndac_o(), .ndac_oe_n(ndac_oe_n), .dio_o(),
      .dio_oe_n(dio_oe_n), .link_data(link_data), .link_req(link_req), .link_ack(ack),
      .link_probe(probe), .link_echo(echo), .link_ppoll(link_ppoll), .link_ppr(ppr),
      .link_slow(link_slow), .fault_led(fault_led));
   gxt_far_node far (.aclk(aclk), .link_req(link_req), .link_probe(probe),
      .link_ppoll(link_ppoll), .ack_dly(ack_dly), .echo_dly(echo_dly), .echo_on(echo_on),
      .ppr_val(ppr_val), .link_ack(ack), .link_echo(echo), .link_ppr(ppr));
   // ==========================================================
   // Helpers.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // The gap after each pulse stands in for the controller's minimum IFC spacing.
   task automatic pulse_ifc();
      ifc_n <= 1'b0;
      repeat (8) @(posedge aclk);
      ifc_n <= 1'b1;
      repeat (ES + 20) @(posedge aclk);
   endtask
   // A zero delay skips the check that NDAC is held through the far side's delay.
   task automatic hs(input logic [7:0] b, input int dly);
      int k;
      dio_n <= ~b;
      dav_n <= 1'b0;
      for (k = 0; k < 30 && link_req !== 1'b1; k++) @(posedge aclk);
      check(link_data, b);
      if (dly > 0) begin
         repeat (dly - 1) @(posedge aclk);
         check(ndac_oe_n, 1'b0);
      end
      for (k = 0; k < 60 && ndac_oe_n !== 1'b1; k++) @(posedge aclk);
      check(ndac_oe_n, 1'b1);
      dav_n <= 1'b1;
      dio_n <= 8'hff;
      for (k = 0; k < 30 && link_req !== 1'b0; k++) @(posedge aclk);
      check(ndac_oe_n, 1'b0);
      for (k = 0; k < 30 && nrfd_oe_n !== 1'b1; k++) @(posedge aclk);
      check(nrfd_oe_n, 1'b1);
   endtask
   task automatic cut_case(input logic [31:0] ctrl, input logic [1:0] eon,
      input logic [7:0] edly, input logic [1:0] exp);
      axi_wr({25'h0, ADDR_CTRL}, ctrl);
      echo_on <= eon;
      echo_dly <= edly;
      pulse_ifc();
      check(fault_led, exp);
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence.
   initial begin
      forever #4 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      check({nrfd_oe_n, ndac_oe_n, dio_oe_n, fault_led}, 12'hbfc);
      axi_rd({25'h0, ADDR_CTRL});
      check(rd, CTRL_RESET);
      axi_rd(32'hc);
      check(rd, 32'h0);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      axi_wr(32'hc, 32'h1);
      check(resp, RESP_SLVERR);
      for (n = 0; n < 4; n++) begin
         lq = lfsr_next(lq);
         ack_dly <= 8'h2 + {4'h0, lq[3:0]};
         hs(lq[15:8], 2 + int'(lq[3:0]));
      end
      lq = lfsr_next(lq);
      ppr_val <= lq[7:0];
      atn_n <= 1'b0;
      eoi_n <= 1'b0;
      for (n = 0; n < 30 && link_ppoll !== 1'b1; n++) @(posedge aclk);
      repeat (4) @(posedge aclk);
      check(dio_oe_n, {24'h0, ~ppr_val});
      atn_n <= 1'b1;
      eoi_n <= 1'b1;
      repeat (10) @(posedge aclk);
      check(dio_oe_n, 8'hff);
      cut_case(32'h1, 2'h3, 8'h4, PORT_NONE);
      cut_case(32'h1, 2'h0, 8'h4, PORT_A);
      axi_rd({25'h0, ADDR_STATUS});
      check(rd, 32'h5);
      ack_dly <= 8'hf0;
      hs(8'h81, 0);
      repeat (300) @(posedge aclk);
      check(fault_led, PORT_A);
      cut_case(32'h1, 2'h3, 8'h4, PORT_NONE);
      cut_case(32'h3, 2'h3, 8'd30, PORT_NONE);
      check(link_slow, 1'b1);
      cut_case(32'h1, 2'h3, 8'd30, PORT_A);
      cut_case(32'h1, 2'h3, 8'h4, PORT_NONE);
      axi_rd({25'h0, ADDR_COUNT});
      check(rd, 32'h6);
      cut_case(32'h0, 2'h0, 8'h4, PORT_NONE);
      cut_case(32'h15, 2'h0, 8'h4, PORT_NONE);
      axi_rd({25'h0, ADDR_STATUS});
      check(rd, 32'h20);
      cut_case(32'h5, 2'h0, 8'h4, PORT_B);
      axi_rd({25'h0, ADDR_COUNT});
      check(rd, 32'h7);
      cut_case(32'h45, 2'h0, 8'h4, PORT_A);
      cut_case(32'h9, 2'h0, 8'h4, PORT_NONE);
      // A slow master closes its poll window after the shortened slow count.
      axi_wr({25'h0, ADDR_CTRL}, 32'h3);
      ppr_val <= 8'h3c;
      atn_n <= 1'b0;
      eoi_n <= 1'b0;
      for (n = 0; n < 30 && link_ppoll !== 1'b1; n++) @(posedge aclk);
      repeat (20) @(posedge aclk);
      check(dio_oe_n, 32'hc3);
      repeat (20) @(posedge aclk);
      check(dio_oe_n, 32'hff);
      finish_test();
   end
endmodule
